// ===== timer_map.vh
// register map, field positions and reset values of the 8-bit timer
// assumes a 100 MHz pclk and word-aligned APB byte addresses
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH
// ****************************************
// register byte addresses
// ****************************************
`define ADDR_CONTROL 8'h00
`define ADDR_COUNT 8'h04
`define ADDR_COMPARE 8'h08
`define ADDR_MASK 8'h0c
`define ADDR_FLAGS 8'h10
// ****************************************
// control fields
// ****************************************
`define CTL_FORCE 7
`define CTL_WAVE_LO 6
`define CTL_ACT_HI 5
`define CTL_ACT_LO 4
`define CTL_WAVE_HI 3
`define CTL_CLK_HI 2
`define CTL_CLK_LO 0
// ****************************************
// mask and flag bit positions
// ****************************************
`define BIT_COMPARE 7
`define BIT_OVERFLOW 6
// ****************************************
// waveform modes
// ****************************************
`define MODE_NORMAL 2'h0
`define MODE_PHASE 2'h1
`define MODE_CLEAR 2'h2
`define MODE_FAST 2'h3
// ****************************************
// counter limits and reset values
// ****************************************
`define COUNT_MAX 8'hff
`define COUNT_BOTTOM 8'h00
`define RESET_BYTE 8'h00
`define PRESC_WIDTH 10
`endif

// ===== timer8_pwm.v
// 8-bit timer/counter with one compare channel, APB register access
// assumes synchronous APB master on pclk; ext_count_pin is asynchronous
// assumes the vector acks are one-cycle pulses from the cpu side on pclk
//
// The APB register port and the register addresses were left to the implementer.
`include "timer_map.vh"

module timer8_pwm (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_count_pin,
  input wire global_irq_en,
  input wire compare_vector_ack,
  input wire overflow_vector_ack,
  input wire port_data_bit,
  input wire port_dir_bit,
  output reg compare_out_pin,
  output reg compare_out_oe,
  output reg compare_irq,
  output reg overflow_irq
);

  // ****************************************
  // state
  // ****************************************
  reg [1:0] wave_mode_sel;
  reg [1:0] compare_out_action;
  reg [2:0] count_clock_sel;
  reg [7:0] timer_count;
  reg [7:0] compare_buf;
  reg [7:0] compare_value;
  reg compare_irq_en;
  reg overflow_irq_en;
  reg compare_match_flag;
  reg overflow_flag;
  reg count_down;
  reg match_block;
  reg wave_out;
  reg [`PRESC_WIDTH-1:0] presc;
  reg ext_sync1;
  reg ext_sync2;
  reg ext_prev;

  // ****************************************
  // bus decode
  // ****************************************
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire wr_ctl = wr & (paddr == `ADDR_CONTROL);
  wire wr_cnt = wr & (paddr == `ADDR_COUNT);
  wire wr_cmp = wr & (paddr == `ADDR_COMPARE);
  wire wr_msk = wr & (paddr == `ADDR_MASK);
  wire wr_flg = wr & (paddr == `ADDR_FLAGS);

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `ADDR_CONTROL) | (a == `ADDR_COUNT) | (a == `ADDR_COMPARE) |
               (a == `ADDR_MASK) | (a == `ADDR_FLAGS);
    end
  endfunction

  // ****************************************
  // count clock selection
  // ****************************************
  // prescaler runs free, so a divided tick may come early after start
  // the edge detector resets low like the idle pin, so no false edge follows reset
  wire all8 = &presc[2:0];
  wire all64 = &presc[5:0];
  wire all256 = &presc[7:0];
  wire all1024 = &presc[9:0];
  wire ext_rise = ext_sync2 & ~ext_prev;
  wire ext_fall = ~ext_sync2 & ext_prev;
  reg tick;

  always @* begin
    case (count_clock_sel)
      3'h1: tick = 1'b1;
      3'h2: tick = all8;
      3'h3: tick = all64;
      3'h4: tick = all256;
      3'h5: tick = all1024;
      3'h6: tick = ext_fall;
      3'h7: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= {`PRESC_WIDTH{1'b0}};
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      presc <= presc + 1'b1;
      ext_sync1 <= ext_count_pin;
      ext_sync2 <= ext_sync1;
      ext_prev <= ext_sync2;
    end
  end

  // ****************************************
  // mode decode
  // ****************************************
  wire is_phase = (wave_mode_sel == `MODE_PHASE);
  wire is_fast = (wave_mode_sel == `MODE_FAST);
  wire is_clear = (wave_mode_sel == `MODE_CLEAR);
  wire non_pwm = ~is_phase & ~is_fast;
  wire at_max = (timer_count == `COUNT_MAX);
  wire at_bottom = (timer_count == `COUNT_BOTTOM);
  wire equal = (timer_count == compare_value);
  wire match = tick & equal & ~match_block;
  // compare at top with the upper action bit set moves the pwm edge to the turning point
  wire top_hold = (compare_value == `COUNT_MAX) & compare_out_action[1];
  wire force_cmp = wr_ctl & pwdata[`CTL_FORCE] & non_pwm;
  // a force strobe acts with the action written alongside it, not the old one
  wire [1:0] act_now = force_cmp ? pwdata[`CTL_ACT_HI:`CTL_ACT_LO] : compare_out_action;
  // the turning tick at bottom begins the up slope: a match there counts as
  // up-counting, so a bottom compare value keeps a non-inverted pin low
  wire up_slope = ~count_down | at_bottom;
  wire [1:0] new_mode = {pwdata[`CTL_WAVE_HI], pwdata[`CTL_WAVE_LO]};
  wire overflow_evt = tick & (is_phase ? (count_down & at_bottom) : at_max);
  wire load_at_top = tick & is_phase & ~count_down & at_max;
  wire load_at_bot = tick & is_fast & at_max;

  // ****************************************
  // counter and compare buffer
  // ****************************************
  // direction survives a stop, so a restarted dual-slope run may first turn at bottom
  reg [7:0] count_next;
  reg down_next;

  always @* begin
    count_next = timer_count + 8'h01;
    down_next = count_down;
    if (is_phase) begin
      if (!count_down) begin
        if (at_max) begin
          down_next = 1'b1;
          count_next = timer_count - 8'h01;
        end
      end else if (at_bottom) begin
        down_next = 1'b0;
      end else begin
        count_next = timer_count - 8'h01;
      end
    end else begin
      down_next = 1'b0;
      // a match blocked by a count write skips the clear as well
      if (is_clear & equal & ~match_block) begin
        count_next = `COUNT_BOTTOM;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= `RESET_BYTE;
      count_down <= 1'b0;
      match_block <= 1'b0;
      compare_buf <= `RESET_BYTE;
      compare_value <= `RESET_BYTE;
    end else begin
      // a count write wins over a tick that falls in the same cycle
      if (wr_cnt) begin
        timer_count <= pwdata[7:0];
        match_block <= 1'b1;
      end else if (tick) begin
        timer_count <= count_next;
        count_down <= down_next;
        match_block <= 1'b0;
      end
      // the bus reads back the buffer, so software sees its last write at once
      if (wr_cmp) begin
        compare_buf <= pwdata[7:0];
      end
      if (non_pwm) begin
        compare_value <= wr_cmp ? pwdata[7:0] : compare_buf;
      end else if (load_at_top | load_at_bot) begin
        compare_value <= compare_buf;
      end
    end
  end

  // ****************************************
  // waveform output
  // ****************************************
  reg wave_next;

  always @* begin
    wave_next = wave_out;
    if (non_pwm) begin
      if (match | force_cmp) begin
        case (act_now)
          2'h1: wave_next = ~wave_out;
          2'h2: wave_next = 1'b0;
          2'h3: wave_next = 1'b1;
          default: wave_next = wave_out;
        endcase
      end
    end else if (compare_out_action[1]) begin
      if (is_fast) begin
        if (load_at_bot) begin
          wave_next = ~compare_out_action[0];
        end else if (match & ~top_hold) begin
          wave_next = compare_out_action[0];
        end
      end else if (top_hold) begin
        if (load_at_top) begin
          wave_next = ~compare_out_action[0];
        end
      end else if (match) begin
        wave_next = up_slope ? compare_out_action[0] : ~compare_out_action[0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_out <= 1'b0;
      compare_out_pin <= 1'b0;
      compare_out_oe <= 1'b0;
    end else begin
      wave_out <= wave_next;
      // pin selection lags the wave by one cycle so the pin stays a flop
      compare_out_pin <= (compare_out_action != 2'h0) ? wave_out : port_data_bit;
      // the driver enable follows the direction bit alone; the action never drives it
      compare_out_oe <= port_dir_bit;
    end
  end

  // ****************************************
  // control, mask and flags
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_mode_sel <= `MODE_NORMAL;
      compare_out_action <= 2'h0;
      count_clock_sel <= 3'h0;
      compare_irq_en <= 1'b0;
      overflow_irq_en <= 1'b0;
      compare_match_flag <= 1'b0;
      overflow_flag <= 1'b0;
      compare_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      if (wr_ctl) begin
        wave_mode_sel <= new_mode;
        compare_out_action <= pwdata[`CTL_ACT_HI:`CTL_ACT_LO];
        count_clock_sel <= pwdata[`CTL_CLK_HI:`CTL_CLK_LO];
      end
      if (wr_msk) begin
        compare_irq_en <= pwdata[`BIT_COMPARE];
        overflow_irq_en <= pwdata[`BIT_OVERFLOW];
      end
      // a hardware set in the clearing cycle wins
      if (match) begin
        compare_match_flag <= 1'b1;
      end else if (compare_vector_ack | (wr_flg & pwdata[`BIT_COMPARE])) begin
        compare_match_flag <= 1'b0;
      end
      // a write of zero to a flag bit leaves it alone
      if (overflow_evt) begin
        overflow_flag <= 1'b1;
      end else if (overflow_vector_ack | (wr_flg & pwdata[`BIT_OVERFLOW])) begin
        overflow_flag <= 1'b0;
      end
      // requests are levels; the cpu side answers a taken vector with an ack pulse
      compare_irq <= compare_match_flag & compare_irq_en & global_irq_en;
      overflow_irq <= overflow_flag & overflow_irq_en & global_irq_en;
    end
  end

  // ****************************************
  // apb response
  // ****************************************
  // one wait state: pready rises the cycle after the access phase starts
  // unmapped addresses answer with an error and read zero; writes to them are dropped
  reg [7:0] rd_byte;

  always @* begin
    case (paddr)
      `ADDR_CONTROL: rd_byte = {1'b0, wave_mode_sel[0], compare_out_action,
                                wave_mode_sel[1], count_clock_sel};
      `ADDR_COUNT: rd_byte = timer_count;
      `ADDR_COMPARE: rd_byte = compare_buf;
      `ADDR_MASK: rd_byte = {compare_irq_en, overflow_irq_en, 6'h00};
      `ADDR_FLAGS: rd_byte = {compare_match_flag, overflow_flag, 6'h00};
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        pslverr <= ~mapped(paddr);
        prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
      end
    end
  end

endmodule // timer8_pwm

// ===== timer8_sva.sv
// checker for the apb handshake, interrupt and driver enable outputs of the timer
// assumes it is bound to timer8_pwm and sees only that module's ports
module timer8_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire global_irq_en,
  input wire port_dir_bit,
  input wire compare_out_oe,
  input wire compare_irq,
  input wire overflow_irq
);
  // ****************************************
  // handshake and output relations
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_one_wait: assert property (s_access |=> s_answer)
    else $error("answer not one wait state and one cycle long");
  a_idle_quiet: assert property (!(psel && penable) |=> !pready)
    else $error("ready without an access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error outside the answer cycle");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_oe_dir: assert property ($past(presetn) |-> compare_out_oe == $past(port_dir_bit))
    else $error("driver enable not following direction");
  a_cmp_gie: assert property (compare_irq |-> $past(global_irq_en))
    else $error("compare request without global enable");
  a_ovf_gie: assert property (overflow_irq |-> $past(global_irq_en))
    else $error("overflow request without global enable");
endmodule // timer8_sva

bind timer8_pwm timer8_sva chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .global_irq_en(global_irq_en),
  .port_dir_bit(port_dir_bit),
  .compare_out_oe(compare_out_oe),
  .compare_irq(compare_irq),
  .overflow_irq(overflow_irq)
);

// ===== tb.sv
// self-checking bench for the 8-bit timer over apb
// assumes timer_map.vh on the include path; no partner model
`include "timer_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ext, gie, cack, oack, pdat, pdir, pin, oe, cirq, oirq;
  int n_errors, check_count, n;
  logic [1:0] tmo[7] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1};
  logic [1:0] tac[7] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3, 2'h2, 2'h2};
  logic [7:0] tcm[7] = '{8'h40, 8'h40, 8'hff, 8'h40, 8'h40, 8'hff, 8'h00};
  int thi[7] = '{130, 382, 512, 256, 764, 1020, 0};
  int sh[4] = '{3, 6, 8, 10};
  timer8_pwm dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_pin(ext), .global_irq_en(gie),
    .compare_vector_ack(cack), .overflow_vector_ack(oack), .port_data_bit(pdat),
    .port_dir_bit(pdir), .compare_out_pin(pin), .compare_out_oe(oe),
    .compare_irq(cirq), .overflow_irq(oirq));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, {24'h0, e});
  endtask
  function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] a,
    input logic [2:0] c);
    return {1'b0, m[0], a, m[1], c};
  endfunction
  task automatic wait_n(input int k);
    repeat (k) @(negedge pclk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rdc("control", `ADDR_CONTROL, 8'h00);
    rdc("count", `ADDR_COUNT, 8'h00);
    rdc("compare", `ADDR_COMPARE, 8'h00);
    rdc("mask", `ADDR_MASK, 8'h00);
    rdc("flags", `ADDR_FLAGS, 8'h00);
    chk("pin", pin, pdat);
    wr(8'h14, 8'h55);
    chk("slverr", err, 1'b1);
  endtask
  task automatic t_ovf;
    gie <= 1'b1;
    wr(`ADDR_COMPARE, 8'h80);
    wr(`ADDR_MASK, 8'h40);
    wr(`ADDR_COUNT, 8'hf0);
    rdc("count rd", `ADDR_COUNT, 8'hf0);
    wr(`ADDR_CONTROL, ctl(`MODE_NORMAL, 2'h0, 3'h1));
    wait_n(20);
    rdc("ovf flag", `ADDR_FLAGS, 8'h40);
    chk("ovf irq", oirq, 1'b1);
    chk("cmp irq", cirq, 1'b0);
    wr(`ADDR_FLAGS, 8'h00);
    rdc("ovf kept", `ADDR_FLAGS, 8'h40);
    wr(`ADDR_FLAGS, 8'h40);
    rdc("ovf clr", `ADDR_FLAGS, 8'h00);
    wait_n(256);
    wr(`ADDR_CONTROL, 8'h00);
    rdc("ovf again", `ADDR_FLAGS, 8'hc0);
    chk("ovf irq on", oirq, 1'b1);
    gie <= 1'b0;
    wait_n(2);
    chk("ovf irq gie", oirq, 1'b0);
    @(posedge pclk);
    gie <= 1'b1;
    oack <= 1'b1;
    @(posedge pclk);
    oack <= 1'b0;
    rdc("ovf ack", `ADDR_FLAGS, 8'h80);
    chk("ovf irq off", oirq, 1'b0);
    wr(`ADDR_FLAGS, 8'h80);
    rdc("cmp w1c", `ADDR_FLAGS, 8'h00);
  endtask
  task automatic t_ctc;
    pdir <= 1'b1;
    wr(`ADDR_COUNT, 8'h00);
    wr(`ADDR_COMPARE, 8'h05);
    wr(`ADDR_MASK, 8'h80);
    wr(`ADDR_CONTROL, ctl(`MODE_CLEAR, 2'h1, 3'h1));
    n = 0;
    repeat (60) begin
      @(negedge pclk);
      if (pin !== oe) n++;
    end
    wr(`ADDR_CONTROL, ctl(`MODE_CLEAR, 2'h1, 3'h0));
    chk("toggles", n > 15 && n < 45, 1'b1);
    apb(1'b0, `ADDR_COUNT, 32'h0);
    chk("ctc top", rd <= 32'h5, 1'b1);
    rdc("cmp flag", `ADDR_FLAGS, 8'h80);
    chk("cmp irq", cirq, 1'b1);
    @(posedge pclk);
    cack <= 1'b1;
    @(posedge pclk);
    cack <= 1'b0;
    wait_n(2);
    rdc("cmp ack", `ADDR_FLAGS, 8'h00);
    chk("cmp irq off", cirq, 1'b0);
  endtask
  task automatic t_force;
    wr(`ADDR_COUNT, 8'h33);
    wr(`ADDR_CONTROL, ctl(`MODE_NORMAL, 2'h3, 3'h0) | 8'h80);
    wait_n(2);
    chk("force set", pin, 1'b1);
    rdc("force rd", `ADDR_CONTROL, ctl(`MODE_NORMAL, 2'h3, 3'h0));
    wr(`ADDR_CONTROL, ctl(`MODE_NORMAL, 2'h2, 3'h0) | 8'h80);
    wait_n(2);
    chk("force clr", pin, 1'b0);
    rdc("no flag", `ADDR_FLAGS, 8'h00);
    rdc("held", `ADDR_COUNT, 8'h33);
    wr(`ADDR_COMPARE, 8'h33);
    wr(`ADDR_CONTROL, ctl(`MODE_NORMAL, 2'h0, 3'h1));
    wait_n(4);
    wr(`ADDR_CONTROL, 8'h00);
    rdc("blocked", `ADDR_FLAGS, 8'h00);
    wait_n(2);
    chk("port back", pin, pdat);
  endtask
  task automatic pulses(input int k);
    repeat (k) begin
      repeat (3) @(posedge pclk);
      ext <= 1'b1;
      repeat (3) @(posedge pclk);
      ext <= 1'b0;
    end
    repeat (6) @(posedge pclk);
  endtask
  task automatic t_ext;
    wr(`ADDR_COUNT, 8'h00);
    wr(`ADDR_CONTROL, ctl(`MODE_NORMAL, 2'h0, 3'h7));
    pulses(4);
    rdc("rise", `ADDR_COUNT, 8'h04);
    wr(`ADDR_CONTROL, ctl(`MODE_NORMAL, 2'h0, 3'h6));
    pulses(3);
    rdc("fall", `ADDR_COUNT, 8'h07);
    wr(`ADDR_CONTROL, 8'h00);
  endtask
  task automatic t_presc;
    for (int c = 2; c <= 5; c++) begin
      wr(`ADDR_COUNT, 8'h00);
      wr(`ADDR_CONTROL, ctl(`MODE_NORMAL, 2'h0, c[2:0]));
      repeat (1536) @(posedge pclk);
      wr(`ADDR_CONTROL, 8'h00);
      apb(1'b0, `ADDR_COUNT, 32'h0);
      n = 1536 >> sh[c - 2];
      chk("prescale", rd + 1 >= n && rd <= n + 2, 1'b1);
    end
  endtask
  // one settling period first, then two whole periods of high samples
  task automatic t_pwm;
    int p;
    for (int i = 0; i < 7; i++) begin
      p = (tmo[i] == `MODE_FAST) ? 256 : 510;
      wr(`ADDR_CONTROL, 8'h00);
      wr(`ADDR_COMPARE, tcm[i]);
      wr(`ADDR_COUNT, 8'h00);
      wr(`ADDR_CONTROL, ctl(tmo[i], tac[i], 3'h1));
      wait_n(p);
      n = 0;
      repeat (2 * p) begin
        @(negedge pclk);
        if (pin === 1'b1) n++;
      end
      p = (tmo[i] == `MODE_FAST) ? 1 : 3;
      chk("high time", n + p >= thi[i] && n <= thi[i] + p, 1'b1);
    end
    wr(`ADDR_CONTROL, 8'h00);
  endtask
  initial begin
    #400us;
    n_errors++;
    test_done;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ext, gie, cack, oack, pdir} = '0;
    pdat = 1'b1;
    n_errors = 0;
    check_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_ovf;
    t_ctc;
    t_force;
    t_ext;
    t_presc;
    t_pwm;
    test_done;
  end
endmodule // tb
